// >>> asr_host.sv
// host controller that drives the 64k x 16 asynchronous sram pins
// How it works
// - data steady 8 ns before write end
// - write cycle 15 ns, pulse 10 ns
// - address steady across the whole write
// - lanes and select lead write end
// - strobe pulse covers setup plus float delay
// - strobe held high through every read
// - address valid before select falls on writes, on the same edge as select on reads
`timescale 1ns/1ps
module asr_host
   import asr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [asr_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [asr_pkg::DATA_W-1:0] reqWdata,
   input wire logic [1:0] reqLanes_n,
   output logic reqReady,
   output logic rspValid,
   output logic [asr_pkg::DATA_W-1:0] rspRdata,
   output logic chipSelect_n,
   output logic outputEnable_n,
   output logic writeStrobe_n,
   output logic low_lane_select_n,
   output logic high_lane_select_n,
   output logic [asr_pkg::ADDR_W-1:0] word_address,
   output logic [asr_pkg::DATA_W-1:0] data_bus_out,
   output logic [asr_pkg::DATA_W-1:0] data_bus_oe,
   input wire logic [asr_pkg::DATA_W-1:0] data_bus_in
);
   import asr_pkg::*;

   // ==========================================
   // reset release
   logic rstMeta_n;
   logic rstSync_n;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // ==========================================
   // data pin input synchroniser
   logic [DATA_W-1:0] dataSync;
   asr_sync #(.W(DATA_W)) uSync (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .din(data_bus_in),
      .dout(dataSync)
   );

   // ==========================================
   // state
   typedef struct packed {
      asr_state_t st;
      logic [CNT_W-1:0] cnt;
      logic ready;
      logic rspValid;
      logic [DATA_W-1:0] rdata;
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic lo_n;
      logic hi_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] doe;
   } asr_regs_t;

   asr_regs_t r;
   asr_regs_t next_r;

   // ==========================================
   // next state
   always_comb begin
      next_r = r;
      next_r.rspValid = 1'b0;
      unique case (r.st)
         ST_IDLE: begin
            // ready returns one cycle after reset release
            if (!r.ready) begin
               next_r.ready = 1'b1;
            end else if (reqValid) begin
               next_r.ready = 1'b0;
               // address, data and lanes placed; a write drops no select or strobe yet, a read drops select and output enable in the same cycle
               next_r.addr = reqAddr;
               next_r.dout = reqWdata;
               next_r.lo_n = reqLanes_n[0];
               next_r.hi_n = reqLanes_n[1];
               if (reqWrite) begin
                  // output enable kept high so the device floats
                  next_r.oe_n = 1'b1;
                  next_r.we_n = 1'b1;
                  next_r.st = ST_WSET;
               end else begin
                  // strobe high for the whole read
                  next_r.we_n = 1'b1;
                  next_r.st = ST_RWAIT;
                  next_r.cs_n = 1'b0;
                  next_r.oe_n = 1'b0;
                  next_r.cnt = READ_WAIT_CNT;
               end
            end
         end
         ST_WSET: begin
            // select, strobe and lanes overlap
            next_r.cs_n = 1'b0;
            next_r.we_n = 1'b0;
            next_r.doe = {{8{~r.hi_n}}, {8{~r.lo_n}}};
            next_r.cnt = WRITE_LOW_CNT;
            next_r.st = ST_WLOW;
         end
         ST_WLOW: begin
            // pulse long enough for setup and float
            if (r.cnt == CNT_W'(1)) begin
               // select and strobe rise together, data held one more cycle
               next_r.cs_n = 1'b1;
               next_r.we_n = 1'b1;
               next_r.lo_n = 1'b1;
               next_r.hi_n = 1'b1;
               next_r.cnt = TURN_CNT;
               next_r.st = ST_TURN;
            end else begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end
         end
         ST_RWAIT: begin
            // wait access time plus sync stages
            if (r.cnt == CNT_W'(1)) begin
               // keep only selected lanes of the sample
               if (r.hi_n) begin
                  next_r.rdata[15:8] = 8'h00;
               end else begin
                  next_r.rdata[15:8] = dataSync[15:8];
               end
               if (r.lo_n) begin
                  next_r.rdata[7:0] = 8'h00;
               end else begin
                  next_r.rdata[7:0] = dataSync[7:0];
               end
               next_r.rspValid = 1'b1;
               next_r.cs_n = 1'b1;
               next_r.oe_n = 1'b1;
               next_r.lo_n = 1'b1;
               next_r.hi_n = 1'b1;
               next_r.cnt = TURN_CNT;
               next_r.st = ST_TURN;
            end else begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end
         end
         ST_TURN: begin
            // release the bus after the device floats
            next_r.doe = '0;
            if (r.cnt == CNT_W'(1)) begin
               next_r.ready = 1'b1;
               next_r.st = ST_IDLE;
            end else begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end
         end
         default: begin
            next_r.st = ST_IDLE;
            next_r.ready = 1'b1;
         end
      endcase
   end

   // ==========================================
   // state register
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         r <= '{
            st: ST_IDLE,
            cnt: '0,
            ready: 1'b0,
            rspValid: 1'b0,
            rdata: '0,
            cs_n: 1'b1,
            oe_n: 1'b1,
            we_n: 1'b1,
            lo_n: 1'b1,
            hi_n: 1'b1,
            addr: '0,
            dout: '0,
            doe: '0
         };
      end else begin
         r <= next_r;
      end
   end

   // ==========================================
   // outputs straight from flip-flops
   assign reqReady = r.ready;
   assign rspValid = r.rspValid;
   assign rspRdata = r.rdata;
   assign chipSelect_n = r.cs_n;
   assign outputEnable_n = r.oe_n;
   assign writeStrobe_n = r.we_n;
   assign low_lane_select_n = r.lo_n;
   assign high_lane_select_n = r.hi_n;
   assign word_address = r.addr;
   assign data_bus_out = r.dout;
   assign data_bus_oe = r.doe;
endmodule

// >>> asr_host_checker.sv
// checker: pin protocol of the sram host controller
`timescale 1ns/1ps
module asr_host_checker
   import asr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic chipSelect_n,
   input wire logic outputEnable_n,
   input wire logic writeStrobe_n,
   input wire logic low_lane_select_n,
   input wire logic high_lane_select_n,
   input wire logic [asr_pkg::ADDR_W-1:0] word_address,
   input wire logic [asr_pkg::DATA_W-1:0] data_bus_out,
   input wire logic [asr_pkg::DATA_W-1:0] data_bus_oe
);
   import asr_pkg::*;
   // ==========
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wr_take;
      reqValid && reqReady && reqWrite;
   endsequence
   sequence s_pulse;
      !writeStrobe_n [*2] ##1 writeStrobe_n;
   endsequence
   a_write_pulse: assert property (s_wr_take |-> ##1 writeStrobe_n ##1 s_pulse)
      else $error("write strobe pulse misplaced");
   a_read_answer: assert property (reqValid && reqReady && !reqWrite |-> ##5 rspValid)
      else $error("read answer late");
   a_strobe_in_read: assert property (!outputEnable_n |-> writeStrobe_n && data_bus_oe == '0)
      else $error("strobe or drive during read");
   a_data_steady: assert property ($fell(writeStrobe_n) |=>
      ($stable(data_bus_out) && $stable(data_bus_oe) && data_bus_oe != '0) [*2])
      else $error("write data moved");
   a_lanes_lead: assert property ($rose(writeStrobe_n) |-> $past(chipSelect_n, 2) == 1'b0
      && $past(chipSelect_n) == 1'b0 && !($past(low_lane_select_n) && $past(high_lane_select_n)))
      else $error("select or lane late");
   a_addr_write: assert property (!writeStrobe_n || $rose(writeStrobe_n) |-> $stable(word_address))
      else $error("address moved in write");
   a_addr_select: assert property (!chipSelect_n && $past(chipSelect_n) == 1'b0
      |-> $stable(word_address))
      else $error("address moved while selected");
endmodule
bind asr_host asr_host_checker u_chk (.clk, .rst_n, .reqValid, .reqWrite, .reqReady, .rspValid,
   .chipSelect_n, .outputEnable_n, .writeStrobe_n, .low_lane_select_n, .high_lane_select_n,
   .word_address, .data_bus_out, .data_bus_oe);

// >>> asr_pkg.sv
// package: pin timing and cycle counts for the sram host controller
package asr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // write timing (ns)
   localparam int WRITE_CYCLE_NS = 15;
   localparam int WRITE_PULSE_NS = 10;
   localparam int WRITE_DATA_SETUP_NS = 8;
   localparam int STROBE_LOW_TO_FLOAT_NS = 7;
   localparam int ADDR_SETUP_END_NS = 10;
   localparam int LANE_TO_END_NS = 9;
   localparam int SELECT_TO_END_NS = 10;
   // read timing
   localparam int READ_CYCLE_NS = 15;
   localparam int ADDRESS_ACCESS_DELAY_NS = 15;
   localparam int SELECT_ACCESS_NS = 15;
   localparam int ENABLE_ACCESS_NS = 7;
   localparam int FLOAT_NS = 7;
   // least times round up
   localparam int PULSE_NS_MAX1 = (WRITE_PULSE_NS > WRITE_DATA_SETUP_NS + STROBE_LOW_TO_FLOAT_NS)
      ? WRITE_PULSE_NS : WRITE_DATA_SETUP_NS + STROBE_LOW_TO_FLOAT_NS;
   localparam int PULSE_NS = (PULSE_NS_MAX1 > WRITE_CYCLE_NS) ? PULSE_NS_MAX1 : WRITE_CYCLE_NS;
   localparam int WRITE_LOW_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_NS = (READ_CYCLE_NS > ADDRESS_ACCESS_DELAY_NS) ? READ_CYCLE_NS
      : ADDRESS_ACCESS_DELAY_NS;
   // two extra cycles cover the two input synchroniser stages
   localparam int READ_WAIT_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
   localparam int TURN_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] WRITE_LOW_CNT = CNT_W'(WRITE_LOW_CYC);
   localparam logic [CNT_W-1:0] READ_WAIT_CNT = CNT_W'(READ_WAIT_CYC);
   localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_WSET = 5'h02,
      ST_WLOW = 5'h04,
      ST_RWAIT = 5'h08,
      ST_TURN = 5'h10
   } asr_state_t;
endpackage

// >>> asr_sram_model.sv
// partner: behavioural 64k x 16 asynchronous sram
`timescale 1ns/1ps
module asr_sram_model #(
   parameter int ACCESS_NS = 15
) (
   input wire logic chipSelect_n,
   input wire logic outputEnable_n,
   input wire logic writeStrobe_n,
   input wire logic low_lane_select_n,
   input wire logic high_lane_select_n,
   input wire logic [15:0] word_address,
   input wire logic [15:0] pins,
   output logic [15:0] devData,
   output logic [15:0] devOe
);
   logic [15:0] mem [65536];
   logic [15:0] rdDly;
   logic rdOn;
   always @* begin
      if (!chipSelect_n && !writeStrobe_n) begin
         if (!low_lane_select_n) mem[word_address][7:0] = pins[7:0];
         if (!high_lane_select_n) mem[word_address][15:8] = pins[15:8];
      end
   end
   assign #(ACCESS_NS) rdDly = mem[word_address];
   assign rdOn = !chipSelect_n && !outputEnable_n && writeStrobe_n;
   assign devData = rdDly;
   assign devOe = {{8{rdOn && !high_lane_select_n}}, {8{rdOn && !low_lane_select_n}}};
endmodule

// >>> asr_sync.sv
// two flip-flop synchroniser for the returning data pins
`timescale 1ns/1ps
module asr_sync #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rstSync_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1;
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// >>> tb_top.sv
// testbench: corner and random traffic through the sram host
`timescale 1ns/1ps
module tb_top;
   import asr_pkg::*;
   logic clk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, reqReady, rspValid;
   logic chipSelect_n, outputEnable_n, writeStrobe_n, lowN, highN;
   logic [15:0] reqAddr = '0, reqWdata = '0, rspRdata, word_address, data_bus_out, data_bus_oe;
   logic [15:0] devData, devOe, pins, floatPat = 16'h3c3c;
   logic [1:0] reqLanes_n = '0;
   logic [31:0] lfsr = 32'h850e;
   logic [15:0] shadow [int];
   int num_errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   always @(posedge clk) floatPat <= {floatPat[14:0], ~floatPat[15]};
   assign pins = (data_bus_out & data_bus_oe) | (devData & devOe & ~data_bus_oe)
      | (floatPat & ~devOe & ~data_bus_oe);
   asr_host uut (.clk, .rst_n, .reqValid, .reqWrite, .reqAddr, .reqWdata, .reqLanes_n, .reqReady,
      .rspValid, .rspRdata, .chipSelect_n, .outputEnable_n, .writeStrobe_n,
      .low_lane_select_n(lowN), .high_lane_select_n(highN), .word_address, .data_bus_out,
      .data_bus_oe, .data_bus_in(pins));
   asr_sram_model #(.ACCESS_NS(15)) dev (.chipSelect_n, .outputEnable_n, .writeStrobe_n,
      .low_lane_select_n(lowN), .high_lane_select_n(highN), .word_address, .pins, .devData, .devOe);
   // ==========
   // helpers
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] lane_mask(logic [1:0] l);
      return {{8{!l[1]}}, {8{!l[0]}}};
   endfunction
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic req(logic w, logic [15:0] a, logic [15:0] d, logic [1:0] l);
      int n;
      logic [15:0] m;
      m = lane_mask(l);
      n = 0;
      while (reqReady !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      if (reqReady !== 1'b1) begin
         num_errors++;
         complete_run();
      end
      {reqValid, reqWrite, reqAddr, reqWdata, reqLanes_n} = {1'b1, w, a, d, l};
      @(posedge clk);
      #1 reqValid = 0;
      n = 0;
      if (w) shadow[a] = (shadow[a] & ~m) | (d & m);
      else while (rspValid !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1 n++;
      end
      if (!w && rspValid !== 1'b1) begin
         num_errors++;
         complete_run();
      end
      if (!w) chk("read data", shadow[a] & m, rspRdata);
      @(posedge clk);
      #1;
   endtask
   // ==========
   // sequence
   initial begin
      logic [15:0] ad [8];
      logic [1:0] l;
      ad = '{16'h0000, 16'hffff, 16'h5555, 16'haaaa, 16'h0, 16'h0, 16'h0, 16'h0};
      repeat (4) @(posedge clk);
      #1 rst_n = 1;
      for (int i = 0; i < 8; i++) begin
         lfsr = nxt(lfsr);
         if (i > 3) ad[i] = lfsr[15:0];
         req(1, ad[i], lfsr[31:16] ^ 16'h1234, 2'b00);
      end
      for (int i = 0; i < 32; i++) req(0, ad[i/4], 16'h0, 2'(i));
      $display("test corner done");
      for (int i = 0; i < 60; i++) begin
         lfsr = nxt(lfsr);
         l = lfsr[5:4];
         if (lfsr[6] && l == 2'b11) l = 2'b00;
         req(lfsr[6], ad[lfsr[2:0]], lfsr[31:16], l);
      end
      $display("test random done");
      rst_n = 0;
      #1 chk("idle pins", 16'h001f, {11'h0, chipSelect_n, outputEnable_n, writeStrobe_n, lowN, highN});
      chk("bus drive", 16'h0000, data_bus_oe);
      repeat (4) @(posedge clk);
      #1 rst_n = 1;
      for (int i = 0; i < 8; i++) req(0, ad[i], 16'h0, 2'b00);
      $display("test reset done");
      complete_run();
   end
endmodule
